// *** logic/cilbp_regs.vh ***
`ifndef CILBP_REGS_VH
`define CILBP_REGS_VH
// ==========================================================================
// predictor geometry
`define CILBP_BHT_ENTRIES   128
`define CILBP_IDX_HI        9
`define CILBP_IDX_LO        3
`define CILBP_CTR_SNT       2'h0
`define CILBP_CTR_WNT       2'h1
`define CILBP_CTR_WT        2'h2
`define CILBP_CTR_ST        2'h3
`define CILBP_CTR_RESET     2'h1
// ==========================================================================
// return stack
`define CILBP_RS_DEPTH      3
`define CILBP_RS_PTR_MAX    2'h3
// ==========================================================================
// flow costs in cycles
`define CILBP_COST_FOLD     4'h0
`define CILBP_COST_DYN      4'h1
`define CILBP_COST_STATIC   4'h4
`define CILBP_COST_RET_OK   4'h4
`define CILBP_COST_NONE     4'h0
// ==========================================================================
// condition failure
`define CILBP_FAIL_BASE     4'h5
`define CILBP_FAIL_FLOOR    4'h3
`define CILBP_ONE_CYC       4'h1
`define CILBP_TWO_CYC       4'h2
`define CILBP_PAIR_CYC      4'h2
// ==========================================================================
// operand need points
`define CILBP_NEED_NORMAL   2'h0
`define CILBP_NEED_EARLY    2'h1
`define CILBP_NEED_LATE     2'h2
// ==========================================================================
// branch classes
`define CILBP_BR_NONE       3'h0
`define CILBP_BR_IMM        3'h1
`define CILBP_BR_REG        3'h2
`define CILBP_BR_PUSH       3'h3
`define CILBP_BR_POP        3'h4
`endif

// *** logic/cilbp_ret_stack.v ***
`timescale 1ns/1ps
`include "cilbp_regs.vh"
// three-entry return-address stack, newest in slot 0
module cilbp_ret_stack (
  input  wire        clock,
  input  wire        reset,
  input  wire        push,
  input  wire [31:0] push_addr,
  input  wire        pop,
  output wire [31:0] top_addr,
  output wire        not_empty
);
  reg [31:0] slot_q [0:`CILBP_RS_DEPTH-1];
  reg [1:0]  count_q;
  integer    i;

  assign top_addr  = slot_q[0];
  assign not_empty = (count_q != 2'h0);

  // ==========================================================================
  // shift stack; overflow drops the deepest slot so newest is kept
  always @(posedge clock) begin
    if (reset) begin
      for (i = 0; i < `CILBP_RS_DEPTH; i = i + 1) begin
        slot_q[i] <= 32'h0;
      end
      count_q <= 2'h0;
    end else if (push) begin
      for (i = `CILBP_RS_DEPTH-1; i > 0; i = i - 1) begin
        slot_q[i] <= slot_q[i-1];
      end
      slot_q[0] <= push_addr;
      if (count_q != `CILBP_RS_PTR_MAX) begin
        count_q <= count_q + 2'h1;
      end
    end else if (pop && not_empty) begin
      for (i = 0; i < `CILBP_RS_DEPTH-1; i = i + 1) begin
        slot_q[i] <= slot_q[i+1];
      end
      slot_q[`CILBP_RS_DEPTH-1] <= 32'h0;
      count_q <= count_q - 2'h1;
    end
  end
endmodule

// *** logic/cilbp_core.v ***
`timescale 1ns/1ps
`include "cilbp_regs.vh"
// Functional notes
// - predictor is 128 direct-mapped entries indexed by address bits 9:3
// - each entry is a 2-bit saturating counter, four strength states
// - only constant-offset branches predicted dynamically; register targets never predicted
// - dynamic hit costs one cycle, zero when folded in prefetch buffer
// - dynamic miss on constant branch predicted statically at dispatch, four cycles
// - three-entry return stack predicts from dispatch stage
// - only unconditional returns predicted; conditional pops silently; empty never predicts
// - push on link branches: immediate, exchange immediate, exchange register
// - pop on link-register returns, pc moves, stack pc loads
// - good return costs four cycles; mismatch of popped address flags mispredict
// - three parallel four-stage pipes: arithmetic, multiply, load/store
// - arithmetic and multiply lock-step; load/store decoupled
// - forwarding from alu, saturate, writebacks; multiplier internal accumulate path
// - latency counts from producer first cycle to alu-point need
// - early operand adds one cycle to producer latency
// - late operand of two-issue consumer subtracts one cycle
// - store-multiple/double sources write-locked against later writers
// - failing one- and two-cycle instructions keep their cycle counts
// - failing multicycle takes min(pass total, max(5 - gap, 3))
// - flag gap counts cycles since flag setter, stalls included
// - same-register writes land in program order, interlocking when needed
// - opposite-condition writers and stores do not interlock; pair costs two
module cilbp_core (
  input  wire        clock,
  input  wire        reset,
  // fetch side
  input  wire        br_valid,
  input  wire [31:0] br_pc,
  input  wire [2:0]  br_class,
  input  wire        br_cond,
  input  wire        br_next_in_buffer,
  input  wire [31:0] br_link_addr,
  // resolution side
  input  wire        res_valid,
  input  wire [31:0] res_pc,
  input  wire        res_taken,
  input  wire        ret_res_valid,
  input  wire [31:0] ret_res_addr,
  // issue side: one consumer against one producer
  input  wire        iss_valid,
  input  wire [3:0]  prod_latency,
  input  wire [3:0]  prod_age,
  input  wire        prod_is_load,
  input  wire [1:0]  cons_need,
  input  wire        cons_two_issue,
  input  wire        cons_reads_prod,
  input  wire        cons_writes_prod,
  input  wire        opposite_cond,
  input  wire        cons_is_store,
  input  wire        store_lock_start,
  input  wire [3:0]  store_lock_cycles,
  input  wire        cons_writes_locked,
  // condition accounting
  input  wire        flag_set,
  input  wire        cond_fail,
  input  wire [3:0]  pass_cycle_total,
  // pipe advance
  input  wire        alu_pipe_busy,
  input  wire        ls_pipe_busy,
  // outputs
  output reg         pred_valid,
  output reg         pred_taken,
  output reg         pred_static,
  output reg  [31:0] pred_target,
  output reg  [3:0]  flow_cost,
  output reg         ret_mispredict,
  output reg         stall,
  output reg  [3:0]  fail_cycles,
  output reg  [3:0]  flag_gap,
  output reg         arith_advance,
  output reg         ls_advance,
  output reg  [1:0]  fwd_select
);
  // ==========================================================================
  // helpers
  function [6:0] bht_index;
    input [31:0] pc;
    begin
      bht_index = pc[`CILBP_IDX_HI:`CILBP_IDX_LO];
    end
  endfunction

  // counter saturates rather than wrapping at either strong state
  function [1:0] ctr_step;
    input [1:0] c;
    input       taken;
    begin
      if (taken) begin
        ctr_step = (c == `CILBP_CTR_ST) ? c : c + 2'h1;
      end else begin
        ctr_step = (c == `CILBP_CTR_SNT) ? c : c - 2'h1;
      end
    end
  endfunction

  function [3:0] max4;
    input [3:0] a;
    input [3:0] b;
    begin
      max4 = (a > b) ? a : b;
    end
  endfunction

  function [3:0] min4;
    input [3:0] a;
    input [3:0] b;
    begin
      min4 = (a < b) ? a : b;
    end
  endfunction

  // ==========================================================================
  // dynamic predictor table and a valid bit per entry
  // aliasing is accepted: address bit 10 and above share entries
  reg [1:0] bht_q [0:`CILBP_BHT_ENTRIES-1];
  reg       bhv_q [0:`CILBP_BHT_ENTRIES-1];
  integer   k;

  wire [6:0] look_idx = bht_index(br_pc);
  wire [6:0] upd_idx  = bht_index(res_pc);
  wire       dyn_hit  = bhv_q[look_idx];
  wire       dyn_tkn  = bht_q[look_idx][1];

  // resolution trains the counter; a fresh entry starts weak
  always @(posedge clock) begin
    if (reset) begin
      for (k = 0; k < `CILBP_BHT_ENTRIES; k = k + 1) begin
        bht_q[k] <= `CILBP_CTR_RESET;
        bhv_q[k] <= 1'b0;
      end
    end else if (res_valid) begin
      bhv_q[upd_idx] <= 1'b1;
      if (bhv_q[upd_idx]) begin
        bht_q[upd_idx] <= ctr_step(bht_q[upd_idx], res_taken);
      end else begin
        bht_q[upd_idx] <= res_taken ? `CILBP_CTR_WT : `CILBP_CTR_WNT;
      end
    end
  end

  // ==========================================================================
  // return stack
  // push and pop in one cycle: push wins, as in the stack module
  wire        is_push     = br_valid && (br_class == `CILBP_BR_PUSH);
  wire        is_pop      = br_valid && (br_class == `CILBP_BR_POP);
  wire        is_imm      = br_valid && (br_class == `CILBP_BR_IMM);
  // a conditional return still pops but never predicts; empty never predicts
  wire        ret_predict = is_pop && !br_cond && rs_full;
  wire [31:0] rs_top;
  wire        rs_full;

  cilbp_ret_stack u_rs (
    .clock     (clock),
    .reset     (reset),
    .push      (is_push),
    .push_addr (br_link_addr),
    .pop       (is_pop),
    .top_addr  (rs_top),
    .not_empty (rs_full)
  );

  // a pending return remembers what was predicted for later compare
  reg        ret_pend_q;
  reg [31:0] ret_addr_q;

  // ==========================================================================
  // prediction and flow cost, registered at dispatch
  always @(posedge clock) begin
    if (reset) begin
      pred_valid  <= 1'b0;
      pred_taken  <= 1'b0;
      pred_static <= 1'b0;
      pred_target <= 32'h0;
      flow_cost   <= `CILBP_COST_NONE;
      ret_pend_q  <= 1'b0;
      ret_addr_q  <= 32'h0;
    end else begin
      pred_valid  <= 1'b0;
      pred_taken  <= 1'b0;
      pred_static <= 1'b0;
      flow_cost   <= `CILBP_COST_NONE;
      // clear first so a new return in the same cycle keeps its pending mark
      if (ret_res_valid) begin
        ret_pend_q <= 1'b0;
      end
      if (is_imm) begin
        pred_valid <= 1'b1;
        // a fold costs nothing because the branch never takes an issue slot
        if (dyn_hit) begin
          pred_taken <= dyn_tkn;
          flow_cost  <= br_next_in_buffer ? `CILBP_COST_FOLD : `CILBP_COST_DYN;
        end else begin
          // static fallback issued from dispatch, taken by default
          pred_static <= 1'b1;
          pred_taken  <= 1'b1;
          flow_cost   <= `CILBP_COST_STATIC;
        end
      end else if (ret_predict) begin
        pred_valid  <= 1'b1;
        pred_taken  <= 1'b1;
        pred_target <= rs_top;
        flow_cost   <= `CILBP_COST_RET_OK;
        ret_pend_q  <= 1'b1;
        ret_addr_q  <= rs_top;
      end
      // register-target branches fall through with no prediction
    end
  end

  // mismatch of popped address against actual return
  // compare uses the value popped at dispatch, not the live stack top
  always @(posedge clock) begin
    if (reset) begin
      ret_mispredict <= 1'b0;
    end else begin
      ret_mispredict <= ret_res_valid && ret_pend_q && (ret_res_addr != ret_addr_q);
    end
  end

  // ==========================================================================
  // interlock scoring
  // one extra bit keeps latency fifteen plus an early need from wrapping
  reg  [4:0] eff_lat;
  reg        hazard;
  wire       need_early   = (cons_need == `CILBP_NEED_EARLY);
  wire       need_late    = (cons_need == `CILBP_NEED_LATE) && cons_two_issue;
  // a store on the opposite condition never reads the other writer's value
  wire       read_exempt  = cons_is_store && opposite_cond;
  wire       write_exempt = opposite_cond;
  always @* begin
    eff_lat = {1'b0, prod_latency};
    if (need_early) begin
      eff_lat = {1'b0, prod_latency} + {1'b0, `CILBP_ONE_CYC};
    end else if (need_late && prod_latency != 4'h0) begin
      // a zero latency cannot go lower; the operand is simply ready
      eff_lat = {1'b0, prod_latency} - {1'b0, `CILBP_ONE_CYC};
    end
    hazard = 1'b0;
    if (cons_reads_prod && !read_exempt && eff_lat > {1'b0, prod_age}) begin
      hazard = 1'b1;
    end
    // a later writer waits until the earlier result has landed
    if (cons_writes_prod && !write_exempt && prod_latency > prod_age) begin
      hazard = 1'b1;
    end
  end

  // store-multiple write lock down-counter
  // a new store restarts the lock; overlapping stores keep the latest length
  reg [3:0] lock_cnt_q;
  always @(posedge clock) begin
    if (reset) begin
      lock_cnt_q <= 4'h0;
    end else if (store_lock_start) begin
      lock_cnt_q <= store_lock_cycles;
    end else if (lock_cnt_q != 4'h0) begin
      lock_cnt_q <= lock_cnt_q - 4'h1;
    end
  end

  wire lock_hit = cons_writes_locked && (lock_cnt_q != 4'h0);

  // registered so issue sees a clean level, at one cycle of reaction
  always @(posedge clock) begin
    if (reset) begin
      stall <= 1'b0;
    end else begin
      stall <= iss_valid && (hazard || lock_hit);
    end
  end

  // ==========================================================================
  // forwarding source: 0 alu, 1 saturate, 2 alu writeback, 3 load/store writeback
  // a non-load result of age two or more is served from the alu writeback copy
  always @(posedge clock) begin
    if (reset) begin
      fwd_select <= 2'h0;
    end else if (iss_valid && cons_reads_prod) begin
      if (prod_is_load) begin
        fwd_select <= 2'h3;
      end else begin
        fwd_select <= (prod_age >= 4'h2) ? 2'h2 : prod_age[1:0];
      end
    end
  end

  // ==========================================================================
  // pipe advance: arithmetic and multiply share one enable, load/store its own
  // load/store ignores the stall so later arithmetic retires under a load
  always @(posedge clock) begin
    if (reset) begin
      arith_advance <= 1'b0;
      ls_advance    <= 1'b0;
    end else begin
      arith_advance <= !alu_pipe_busy && !stall;
      ls_advance    <= !ls_pipe_busy;
    end
  end

  // ==========================================================================
  // flag gap: counts every cycle since the setter, stalls included
  // the instruction right after the setter sees gap zero
  // saturating keeps a long quiet stretch from wrapping to a small gap
  reg [3:0] gap_q;
  always @(posedge clock) begin
    if (reset) begin
      gap_q <= 4'h0;
    end else if (flag_set) begin
      gap_q <= 4'h0;
    end else if (gap_q != 4'hf) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  // gap saturates so a long distance simply gives the floor
  wire [3:0] gap_eff  = (gap_q >= `CILBP_FAIL_BASE) ? `CILBP_FAIL_BASE : gap_q;
  wire [3:0] fail_mc  = min4(pass_cycle_total, max4(`CILBP_FAIL_BASE - gap_eff,
                                                    `CILBP_FAIL_FLOOR));

  // one- and two-cycle failures keep their count; longer ones shrink with gap
  // an opposite-condition writer pair reports its fixed two-cycle cost when no condition failure is reported
  always @(posedge clock) begin
    if (reset) begin
      fail_cycles <= 4'h0;
      flag_gap    <= 4'h0;
    end else begin
      flag_gap <= gap_q;
      if (cond_fail) begin
        if (pass_cycle_total <= `CILBP_TWO_CYC) begin
          fail_cycles <= pass_cycle_total;
        end else begin
          fail_cycles <= fail_mc;
        end
      end else if (iss_valid && cons_writes_prod && opposite_cond) begin
        fail_cycles <= `CILBP_PAIR_CYC;
      end else begin
        fail_cycles <= 4'h0;
      end
    end
  end
endmodule

// *** bench/cilbp_core_checker.sv ***
`timescale 1ns/1ps
// =====
// port-level timing relations of the core
module cilbp_core_checker (
  input wire       clock,
  input wire       reset,
  input wire       br_valid,
  input wire [2:0] br_class,
  input wire       br_cond,
  input wire       br_next_in_buffer,
  input wire       iss_valid,
  input wire [3:0] prod_latency,
  input wire [3:0] prod_age,
  input wire [1:0] cons_need,
  input wire       cons_two_issue,
  input wire       cons_reads_prod,
  input wire       cons_writes_prod,
  input wire       opposite_cond,
  input wire       store_lock_start,
  input wire [3:0] store_lock_cycles,
  input wire       cons_writes_locked,
  input wire       flag_set,
  input wire       cond_fail,
  input wire [3:0] pass_cycle_total,
  input wire       pred_valid,
  input wire       pred_taken,
  input wire       pred_static,
  input wire [3:0] flow_cost,
  input wire       stall,
  input wire [3:0] fail_cycles,
  input wire [3:0] flag_gap,
  input wire       prod_is_load,
  input wire       cons_is_store,
  input wire       alu_pipe_busy,
  input wire       ls_pipe_busy,
  input wire       arith_advance,
  input wire       ls_advance,
  input wire [1:0] fwd_select
);
  // latency seen by the consumer; wraps for latency 0 late, so those are skipped
  wire [4:0] eff = prod_latency + (cons_need == 2'h1) - (cons_need == 2'h2 && cons_two_issue);
  // flag_gap lags the internal count by one edge, so it is read in the consequent
  wire [3:0] gap_cap = (flag_gap > 4'h1) ? 4'h3 : 4'h5 - flag_gap;
  wire       rd_exempt = cons_is_store && opposite_cond;
  wire       opp_wr = iss_valid && opposite_cond && cons_writes_prod;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_reg_target: assert property (br_valid && br_class == 3'h2 |=> !pred_valid)
    else $error("register target was predicted");
  a_imm_cost: assert property (br_valid && br_class == 3'h1 |=> pred_valid &&
    (pred_static ? pred_taken && flow_cost == 4'h4 : flow_cost == {3'h0, !$past(br_next_in_buffer)}))
    else $error("branch cost wrong");
  a_cond_return: assert property (br_valid && br_class == 3'h4 && br_cond |=> !pred_valid)
    else $error("conditional return was predicted");
  a_read_stall: assert property (iss_valid && cons_reads_prod && prod_latency != 4'h0
    && !rd_exempt && eff > prod_age |=> stall) else $error("missing read interlock");
  a_no_stall: assert property (iss_valid && !cons_writes_prod && !cons_writes_locked
    && (!cons_reads_prod || rd_exempt || eff <= prod_age) |=> !stall)
    else $error("needless interlock");
  a_write_order: assert property (iss_valid && cons_writes_prod && !opposite_cond
    && prod_latency > prod_age |=> stall) else $error("write order unprotected");
  a_opposite_pair: assert property (opp_wr && !cons_reads_prod && !cons_writes_locked
    |=> !stall) else $error("opposite writers interlocked");
  a_store_lock: assert property (store_lock_start && store_lock_cycles > 4'h2 ##1
    iss_valid && cons_writes_locked |=> stall) else $error("locked source overwritten");
  a_fail_short: assert property (cond_fail && pass_cycle_total <= 4'h2 && !opp_wr
    |=> fail_cycles == $past(pass_cycle_total)) else $error("short failing count wrong");
  a_fail_long: assert property (cond_fail && pass_cycle_total > 4'h2 && !opp_wr
    |=> fail_cycles == (($past(pass_cycle_total) < gap_cap) ? $past(pass_cycle_total) : gap_cap))
    else $error("multicycle failing count wrong");
  a_gap_count: assert property (flag_set |=> ##1 flag_gap == 4'h0
    ##1 ($past(flag_set, 2) || flag_gap == 4'h1)) else $error("flag gap count wrong");
  a_arith_lockstep: assert property (1'b1 |=> arith_advance ==
    (!$past(alu_pipe_busy) && !$past(stall))) else $error("arithmetic advance wrong");
  a_ls_decoupled: assert property (!ls_pipe_busy |=> ls_advance)
    else $error("load/store pipe held back");
  a_ls_hold: assert property (ls_pipe_busy |=> !ls_advance)
    else $error("busy load/store pipe advanced");
  a_fwd_load: assert property (iss_valid && cons_reads_prod && prod_is_load
    |=> fwd_select == 2'h3) else $error("load result not forwarded from writeback");
  a_fwd_late: assert property (iss_valid && cons_reads_prod && !prod_is_load
    && prod_age >= 4'h2 |=> fwd_select == 2'h2) else $error("old result not from writeback");
  a_pair_cost: assert property (opp_wr && !cond_fail |=> fail_cycles == 4'h2)
    else $error("opposite writer pair cost wrong");
endmodule

bind cilbp_core cilbp_core_checker u_chk (.clock, .reset, .br_valid, .br_class, .br_cond,
  .br_next_in_buffer, .iss_valid, .prod_latency, .prod_age, .cons_need, .cons_two_issue,
  .cons_reads_prod, .cons_writes_prod, .opposite_cond, .store_lock_start, .store_lock_cycles,
  .cons_writes_locked, .flag_set, .cond_fail, .pass_cycle_total, .pred_valid, .pred_taken,
  .pred_static, .flow_cost, .stall, .fail_cycles, .flag_gap, .prod_is_load, .cons_is_store,
  .alu_pipe_busy, .ls_pipe_busy, .arith_advance, .ls_advance, .fwd_select);

// *** bench/cilbp_exec_model.sv ***
`timescale 1ns/1ps
// =====
// execute side: resolves fetched branches two edges later
module cilbp_exec_model (
  input  wire        clock,
  input  wire        reset,
  input  wire        br_valid,
  input  wire [31:0] br_pc,
  input  wire [2:0]  br_class,
  input  wire        br_cond,
  input  wire        res_dir,
  input  wire        ret_en,
  input  wire [31:0] ret_addr,
  output reg         res_valid,
  output reg  [31:0] res_pc,
  output reg         res_taken,
  output reg         ret_res_valid,
  output reg  [31:0] ret_res_addr
);
  reg        imm_s, ret_s, dir_s;
  reg [31:0] pc_s, ra_s;
  initial {imm_s, ret_s, res_valid, ret_res_valid, res_taken, res_pc, ret_res_addr} = '0;
  // idle outputs flip so stale values never look valid
  always @(posedge clock) begin
    imm_s <= !reset && br_valid && br_class == 3'h1;
    ret_s <= !reset && br_valid && br_class == 3'h4 && !br_cond && ret_en;
    dir_s <= res_dir;
    pc_s <= br_pc;
    ra_s <= ret_addr;
    res_valid <= imm_s;
    res_taken <= imm_s ? dir_s : !res_taken;
    res_pc <= imm_s ? pc_s : ~res_pc;
    ret_res_valid <= ret_s;
    ret_res_addr <= ret_s ? ra_s : ~ret_res_addr;
  end
endmodule

// *** bench/cilbp_core_tb.sv ***
`timescale 1ns/1ps
// =====
// predictor, return stack and interlock bench
module cilbp_core_tb;
  reg         clock = 0;
  reg         reset = 1;
  reg         br_valid = 0, br_cond = 0, br_next_in_buffer = 0, res_dir = 0, ret_en = 0;
  reg         iss_valid = 0, prod_is_load = 0, cons_two_issue = 0, cons_reads_prod = 0;
  reg         cons_writes_prod = 0, opposite_cond = 0, cons_is_store = 0, mis1 = 0;
  reg         store_lock_start = 0, cons_writes_locked = 0, flag_set = 0, cond_fail = 0;
  reg         alu_pipe_busy = 0, ls_pipe_busy = 0;
  reg  [1:0]  cons_need = 0;
  reg  [2:0]  br_class = 0, cls_d = 0;
  reg  [3:0]  prod_latency = 0, prod_age = 0, store_lock_cycles = 0, pass_cycle_total = 0;
  reg  [16:0] a, b = 17'h1557d; // seed 87421
  reg  [31:0] br_pc = 0, br_link_addr = 0, ret_addr = 0;
  reg  [38:0] n;
  reg  [38:0] notes [$];
  reg         mq [$];
  wire        res_valid, res_taken, ret_res_valid, pred_valid, pred_taken, pred_static;
  wire        ret_mispredict, stall, arith_advance, ls_advance;
  wire [1:0]  fwd_select;
  wire [3:0]  flow_cost, fail_cycles, flag_gap;
  wire [31:0] res_pc, ret_res_addr, pred_target;
  integer     miscompares = 0, checks_done = 0, i;

  always #2.5 clock = ~clock;

  cilbp_core DUT (.clock, .reset, .br_valid, .br_pc, .br_class, .br_cond, .br_next_in_buffer,
    .br_link_addr, .res_valid, .res_pc, .res_taken, .ret_res_valid, .ret_res_addr, .iss_valid,
    .prod_latency, .prod_age, .prod_is_load, .cons_need, .cons_two_issue, .cons_reads_prod,
    .cons_writes_prod, .opposite_cond, .cons_is_store, .store_lock_start, .store_lock_cycles,
    .cons_writes_locked, .flag_set, .cond_fail, .pass_cycle_total, .alu_pipe_busy,
    .ls_pipe_busy, .pred_valid, .pred_taken, .pred_static, .pred_target, .flow_cost,
    .ret_mispredict, .stall, .fail_cycles, .flag_gap, .arith_advance, .ls_advance, .fwd_select);

  cilbp_exec_model u_exec (.clock, .reset, .br_valid, .br_pc, .br_class, .br_cond, .res_dir,
    .ret_en, .ret_addr, .res_valid, .res_pc, .res_taken, .ret_res_valid, .ret_res_addr);

  // 17 shifts per draw so neighbouring draws are not one bit apart
  function [16:0] lfsr_next(input [16:0] s);
    integer k;
    begin
      for (k = 0; k < 17; k = k + 1)
        s = {s[15:0], s[16] ^ s[13]};
      lfsr_next = s;
    end
  endfunction

  task check(input [38:0] seen, input [38:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // one fetch, then a gap long enough for the resolution to train
  task fetch(input [2:0] cls, input [31:0] pc, input c, input fold);
    begin
      @(negedge clock);
      br_valid = 1;
      br_class = cls;
      br_pc = pc;
      br_cond = c;
      br_next_in_buffer = fold;
      br_link_addr = pc + 32'h4;
      @(negedge clock);
      br_valid = 0;
      br_pc = ~pc;
      repeat (4) @(negedge clock);
    end
  endtask

  task br_step(input [31:0] pc, input d, input f, input st, input tk, input [3:0] c);
    begin
      res_dir = d;
      notes.push_back({1'b0, st, tk, c, 32'h0});
      fetch(3'h1, pc, 1'b0, f);
    end
  endtask

  task ret_step(input [31:0] e, input w);
    begin
      notes.push_back({3'h4, 4'h4, e});
      mq.push_back(w);
      ret_addr = w ? ~e : e;
      fetch(3'h4, 32'h30000000, 1'b0, 1'b0);
    end
  endtask

  // pushes give no note, so their class is tracked to skip them
  always @(posedge clock) begin
    cls_d <= br_class;
    mis1 <= ret_res_valid;
  end

  // outputs are settled by the falling edge
  always @(negedge clock) begin
    if (pred_valid === 1'b1 && cls_d != 3'h3) begin
      if (notes.size() == 0)
        check(39'h1, 39'h0);
      else begin
        n = notes.pop_front();
        if (n[38])
          check({3'h4, flow_cost, pred_target}, n);
        else
          check({1'b0, pred_static, pred_taken, flow_cost, 32'h0}, n);
      end
    end
    if (mis1)
      check({38'h0, ret_mispredict}, {38'h0, mq.pop_front()});
  end

  initial begin
    #100000;
    miscompares = miscompares + 1;
    conclude;
  end

  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    reset = 0;
    br_step(32'h10000040, 1, 0, 1, 1, 4'h4);
    br_step(32'h10000440, 1, 0, 0, 1, 4'h1); // bit 10 aliases to the same entry
    br_step(32'h10000040, 1, 0, 0, 1, 4'h1);
    br_step(32'h10000040, 0, 1, 0, 1, 4'h0);
    br_step(32'h10000040, 0, 0, 0, 1, 4'h1);
    br_step(32'h10000040, 0, 0, 0, 0, 4'h1);
    br_step(32'h10000048, 0, 0, 1, 1, 4'h4); // bit 3 picks a fresh entry
    fetch(3'h2, 32'h10000040, 1'b0, 1'b0);
    $display("test predictor done");
    ret_en = 1;
    for (i = 0; i < 4; i = i + 1)
      fetch(3'h3, 32'h20000000 + 16 * i, 1'b0, 1'b0);
    fetch(3'h4, 32'h30000000, 1'b1, 1'b0); // conditional pop drops newest
    ret_step(32'h20000024, 1'b0);
    ret_step(32'h20000014, 1'b1);
    ret_en = 0;
    fetch(3'h4, 32'h30000000, 1'b0, 1'b0); // oldest push was discarded
    $display("test return stack done");
    for (i = 0; i < 400; i = i + 1) begin
      @(negedge clock);
      a = lfsr_next(b);
      b = lfsr_next(a);
      {prod_is_load, cons_is_store, prod_age, prod_latency} = a[16:7];
      {cons_two_issue, opposite_cond, cons_writes_prod, cons_reads_prod, iss_valid} = a[4:0];
      cons_need = (a[6:5] == 2'h3) ? 2'h0 : a[6:5];
      flag_set = b[0] & b[1];
      cond_fail = b[2];
      pass_cycle_total = b[6:3];
      store_lock_start = b[7] & b[8] & b[9];
      store_lock_cycles = b[13:10];
      cons_writes_locked = b[14] & b[15];
      alu_pipe_busy = b[16];
      ls_pipe_busy = b[0] ^ b[16];
    end
    @(negedge clock);
    {iss_valid, cond_fail, flag_set, store_lock_start} = 4'h0;
    $display("test interlock done");
    repeat (8) @(negedge clock);
    check(notes.size() + mq.size(), 39'h0);
    conclude;
  end
endmodule
